//--- logic/lmsc_pkg.sv
// Purpose: shared constants for LED matrix sequence control
// Assumes: 100 MHz core clock, serial register port
// Notes: offsets are 7-bit serial sub-addresses
// Contract
// - first frame field picks start ROM pattern
// - last frame field picks end; reset zero
// - repeat runs when matrix and repeat on
// - repeat control ignored during ROM copy
// - scroll on rising clears repeat on
// - repeat on rising clears scroll on
// - frame period 1 to 4 seconds
// - clear bits erase buffers, self clear 2 clocks
// - scroll shows columns A to G per step
// - scroll pattern writes go to empty buffer
// - scroll runs when matrix and scroll on
// - scroll control ignored during ROM copy
// - scroll step 0.1 to 0.8 seconds
// - colour source field selects register or ROM
// - matrix on bit lights the matrix
// - copy go self clears after 51 clocks
// - refused enable write raises copy flag
package lmsc_pkg;
	localparam int unsigned ADDR_W        = 7;
	localparam int unsigned RD_FLAG_BIT   = 7;
	localparam logic [6:0]  ADDR_MATRIX   = 7'h20;
	localparam logic [6:0]  ADDR_COPY     = 7'h24;
	localparam logic [6:0]  ADDR_FIRST    = 7'h25;
	localparam logic [6:0]  ADDR_LAST     = 7'h26;
	localparam logic [6:0]  ADDR_REPEAT   = 7'h27;
	localparam logic [6:0]  ADDR_RPERIOD  = 7'h28;
	localparam logic [6:0]  ADDR_CLEAR    = 7'h29;
	localparam logic [6:0]  ADDR_SCROLL   = 7'h2A;
	localparam logic [6:0]  ADDR_SPERIOD  = 7'h2B;
	localparam logic [6:0]  ADDR_COLOUR   = 7'h2C;
	localparam logic [6:0]  ADDR_CSOURCE  = 7'h2D;
	localparam logic [6:0]  ADDR_TEST     = 7'h2E;
	localparam logic [6:0]  ADDR_STATUS   = 7'h2F;
	localparam logic [6:0]  ADDR_PAT_LO   = 7'h31;
	localparam logic [6:0]  ADDR_PAT_HI   = 7'h61;
	localparam int unsigned BIT_ENABLE    = 0;
	localparam int unsigned BIT_CLR_ONE   = 1;
	localparam int unsigned BIT_CLR_TWO   = 0;
	localparam logic [7:0]  MASK_BIT0     = 8'h01;
	localparam logic [7:0]  MASK_CLEAR    = 8'h03;
	localparam logic [7:0]  MASK_PERIOD   = 8'h03;
	localparam logic [7:0]  MASK_SOURCE   = 8'h3F;
	localparam logic [7:0]  REG_RESET     = 8'h00;
	localparam logic [2:0]  COLUMN_LAST   = 3'h6;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned NS_PER_MS     = 1000000;
	localparam int unsigned FRAME_UNIT_MS = 1000;
	localparam int unsigned SCROLL_UNIT_MS = 100;
	localparam logic [1:0]  CLEAR_CYC     = 2'h2;
	localparam logic [5:0]  COPY_CYC      = 6'h33;
endpackage

//--- logic/lmsc_serial_port.sv
// Purpose: serial register port, sampled on the core clock
// Assumes: port clock well below core clock
// Notes: address bit 7 high marks a read
module lmsc_serial_port
	import lmsc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        ser_clk,
	input  wire logic        ser_ce,
	input  wire logic        ser_di,
	input  wire logic [7:0]  rd_data,
	output logic             wr_stb,
	output logic [7:0]       wr_addr,
	output logic [7:0]       wr_data,
	output logic             rd_load,
	output logic [7:0]       rd_addr,
	output logic             ser_do,
	output logic             ser_do_oe
);
	logic [2:0]  s1_ff, s2_ff, s3_ff, lvl_ff, nxt_lvl;
	logic [4:0]  cnt_ff, nxt_cnt;
	logic [15:0] sh_ff, nxt_sh;
	logic [7:0]  out_ff, nxt_out;
	logic        rd_ff, nxt_rd, do_ff, nxt_do;
	logic        wr_ff, nxt_wr, ld_ff, nxt_ld, rise, fall;
	logic [7:0]  wa_ff, nxt_wa, wd_ff, nxt_wd, ra_ff, nxt_ra;

	// Bit 0 port clock, 1 enable, 2 data; a change counts once stages agree
	always_comb begin
		nxt_lvl = lvl_ff;
		for (int i = 0; i < 3; i++) begin
			if (s2_ff[i] == s3_ff[i]) nxt_lvl[i] = s3_ff[i];
		end
	end
	assign rise = nxt_lvl[0] & ~lvl_ff[0];
	assign fall = ~nxt_lvl[0] & lvl_ff[0];

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_sh  = sh_ff;
		nxt_rd  = rd_ff;
		nxt_out = out_ff;
		nxt_do  = do_ff;
		nxt_wr  = 1'b0;
		nxt_ld  = 1'b0;
		nxt_wa  = wa_ff;
		nxt_wd  = wd_ff;
		nxt_ra  = ra_ff;
		if (!nxt_lvl[1]) begin
			nxt_cnt = 5'h00;
			nxt_rd  = 1'b0;
		end else if (rise) begin
			nxt_sh  = {sh_ff[14:0], nxt_lvl[2]};
			nxt_cnt = cnt_ff + 5'h01;
			if (cnt_ff == 5'h07 && nxt_sh[RD_FLAG_BIT]) begin
				nxt_rd = 1'b1;
				nxt_ld = 1'b1;
				nxt_ra = nxt_sh[7:0];
			end
			if (cnt_ff == 5'h0F && !rd_ff) begin
				nxt_wr = 1'b1;
				nxt_wa = nxt_sh[15:8];
				nxt_wd = nxt_sh[7:0];
			end
		end else if (fall && rd_ff) begin
			nxt_do  = out_ff[7];
			nxt_out = {out_ff[6:0], 1'b0};
		end
		if (ld_ff) nxt_out = rd_data;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_ff  <= 3'h0;
			s2_ff  <= 3'h0;
			s3_ff  <= 3'h0;
			lvl_ff <= 3'h0;
			cnt_ff <= 5'h00;
			sh_ff  <= 16'h0000;
			rd_ff  <= 1'b0;
			out_ff <= 8'h00;
			do_ff  <= 1'b0;
			wr_ff  <= 1'b0;
			ld_ff  <= 1'b0;
			wa_ff  <= 8'h00;
			wd_ff  <= 8'h00;
			ra_ff  <= 8'h00;
		end else begin
			s1_ff  <= {ser_di, ser_ce, ser_clk};
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			lvl_ff <= nxt_lvl;
			cnt_ff <= nxt_cnt;
			sh_ff  <= nxt_sh;
			rd_ff  <= nxt_rd;
			out_ff <= nxt_out;
			do_ff  <= nxt_do;
			wr_ff  <= nxt_wr;
			ld_ff  <= nxt_ld;
			wa_ff  <= nxt_wa;
			wd_ff  <= nxt_wd;
			ra_ff  <= nxt_ra;
		end
	end

	assign wr_stb    = wr_ff;
	assign wr_addr   = wa_ff;
	assign wr_data   = wd_ff;
	assign rd_load   = ld_ff;
	assign rd_addr   = ra_ff;
	assign ser_do    = do_ff;
	assign ser_do_oe = rd_ff;
endmodule // lmsc_serial_port

//--- logic/lmsc_sequencer.sv
// Purpose: control registers, repeat and scroll sequencing
// Assumes: registers written over the serial port only
// Notes: long periods are parameters for short simulations
module lmsc_sequencer
	import lmsc_pkg::*;
#(
	parameter int unsigned FRAME_UNIT_CYC  = FRAME_UNIT_MS * NS_PER_MS / CLK_PERIOD_NS,
	parameter int unsigned SCROLL_UNIT_CYC = SCROLL_UNIT_MS * NS_PER_MS / CLK_PERIOD_NS
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        ser_clk,
	input  wire logic        ser_ce,
	input  wire logic        ser_di,
	output logic             ser_do,
	output logic             ser_do_oe,
	output logic             matrix_on,
	output logic             repeat_active,
	output logic [7:0]       display_frame,
	output logic             scroll_active,
	output logic             scroll_buffer,
	output logic [2:0]       scroll_column,
	output logic             pattern_wr_stb,
	output logic [6:0]       pattern_wr_addr,
	output logic [7:0]       pattern_wr_data,
	output logic             pattern_wr_buffer,
	output logic             clear_buffer_one,
	output logic             clear_buffer_two,
	output logic             rom_copy_busy,
	output logic             colour_unit_on,
	output logic [5:0]       colour_source_select,
	output logic             copy_active_flag
);
	localparam int RT_W = $clog2(FRAME_UNIT_CYC + 1);
	localparam int ST_W = $clog2(SCROLL_UNIT_CYC + 1);

	function automatic logic [7:0] field(input logic [7:0] d, input logic [7:0] m);
		return d & m;
	endfunction

	function automatic logic [2:0] scroll_last_unit(input logic [1:0] code);
		return 3'((4'h1 << code) - 4'h1);
	endfunction

	logic        wr_stb, rd_load;
	logic [7:0]  wr_addr, wr_data, rd_addr, rd_data;
	logic [6:0]  wa;

	lmsc_serial_port u_port (
		.clk       (clk),
		.reset_n   (reset_n),
		.ser_clk   (ser_clk),
		.ser_ce    (ser_ce),
		.ser_di    (ser_di),
		.rd_data   (rd_data),
		.wr_stb    (wr_stb),
		.wr_addr   (wr_addr),
		.wr_data   (wr_data),
		.rd_load   (rd_load),
		.rd_addr   (rd_addr),
		.ser_do    (ser_do),
		.ser_do_oe (ser_do_oe)
	);
	assign wa = wr_addr[ADDR_W-1:0];

	logic        matrix_ff, nxt_matrix, repeat_ff, nxt_repeat, scroll_ff, nxt_scroll;
	logic        colour_ff, nxt_colour, busy_ff, nxt_busy, flag_ff, nxt_flag;
	logic [7:0]  first_ff, nxt_first, last_ff, nxt_last;
	logic [1:0]  rper_ff, nxt_rper, sper_ff, nxt_sper, clr_ff, nxt_clr, ccnt_ff, nxt_ccnt;
	logic [5:0]  src_ff, nxt_src, bcnt_ff, nxt_bcnt;
	logic        flag_clear;

	assign flag_clear = rd_load && rd_addr[ADDR_W-1:0] == ADDR_STATUS;

	always_comb begin
		nxt_matrix = matrix_ff;
		nxt_first  = first_ff;
		nxt_last   = last_ff;
		nxt_repeat = repeat_ff;
		nxt_rper   = rper_ff;
		nxt_clr    = clr_ff;
		nxt_ccnt   = ccnt_ff;
		nxt_scroll = scroll_ff;
		nxt_sper   = sper_ff;
		nxt_colour = colour_ff;
		nxt_src    = src_ff;
		nxt_busy   = busy_ff;
		nxt_bcnt   = bcnt_ff;
		nxt_flag   = flag_ff;
		if (ccnt_ff != 2'h0) nxt_ccnt = ccnt_ff - 2'h1;
		if (ccnt_ff == 2'h1) nxt_clr = 2'h0;
		if (bcnt_ff != 6'h00) nxt_bcnt = bcnt_ff - 6'h01;
		if (bcnt_ff == 6'h01) nxt_busy = 1'b0;
		if (flag_clear) nxt_flag = 1'b0;
		if (wr_stb) begin
			case (wa)
				ADDR_MATRIX: nxt_matrix = wr_data[BIT_ENABLE];
				ADDR_COPY: begin
					if (!busy_ff && wr_data[BIT_ENABLE]) begin
						nxt_busy = 1'b1;
						nxt_bcnt = COPY_CYC;
					end
				end
				ADDR_FIRST: nxt_first = wr_data;
				ADDR_LAST: nxt_last = wr_data;
				ADDR_REPEAT: begin
					if (busy_ff) begin
						nxt_flag = 1'b1;
					end else begin
						nxt_repeat = wr_data[BIT_ENABLE];
						if (wr_data[BIT_ENABLE] && !repeat_ff) nxt_scroll = 1'b0;
					end
				end
				ADDR_RPERIOD: nxt_rper = 2'(field(wr_data, MASK_PERIOD));
				ADDR_CLEAR: begin
					if (field(wr_data, MASK_CLEAR) != REG_RESET) begin
						nxt_clr  = 2'(field(wr_data, MASK_CLEAR));
						nxt_ccnt = CLEAR_CYC;
					end
				end
				ADDR_SCROLL: begin
					if (busy_ff) begin
						nxt_flag = 1'b1;
					end else begin
						nxt_scroll = wr_data[BIT_ENABLE];
						if (wr_data[BIT_ENABLE] && !scroll_ff) nxt_repeat = 1'b0;
					end
				end
				ADDR_SPERIOD: nxt_sper = 2'(field(wr_data, MASK_PERIOD));
				ADDR_COLOUR: nxt_colour = wr_data[BIT_ENABLE];
				ADDR_CSOURCE: nxt_src = 6'(field(wr_data, MASK_SOURCE));
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			matrix_ff <= 1'b0;
			first_ff  <= REG_RESET;
			last_ff   <= REG_RESET;
			repeat_ff <= 1'b0;
			rper_ff   <= 2'h0;
			clr_ff    <= 2'h0;
			ccnt_ff   <= 2'h0;
			scroll_ff <= 1'b0;
			sper_ff   <= 2'h0;
			colour_ff <= 1'b0;
			src_ff    <= 6'h00;
			busy_ff   <= 1'b0;
			bcnt_ff   <= 6'h00;
			flag_ff   <= 1'b0;
		end else begin
			matrix_ff <= nxt_matrix;
			first_ff  <= nxt_first;
			last_ff   <= nxt_last;
			repeat_ff <= nxt_repeat;
			rper_ff   <= nxt_rper;
			clr_ff    <= nxt_clr;
			ccnt_ff   <= nxt_ccnt;
			scroll_ff <= nxt_scroll;
			sper_ff   <= nxt_sper;
			colour_ff <= nxt_colour;
			src_ff    <= nxt_src;
			busy_ff   <= nxt_busy;
			bcnt_ff   <= nxt_bcnt;
			flag_ff   <= nxt_flag;
		end
	end

	// Read answer, sampled by the port in the cycle rd_load is high
	always_comb begin
		case (rd_addr[ADDR_W-1:0])
			ADDR_MATRIX: rd_data = 8'(matrix_ff);
			ADDR_COPY: rd_data = 8'(busy_ff);
			ADDR_FIRST: rd_data = first_ff;
			ADDR_LAST: rd_data = last_ff;
			ADDR_REPEAT: rd_data = busy_ff ? REG_RESET : 8'(repeat_ff);
			ADDR_RPERIOD: rd_data = 8'(rper_ff);
			ADDR_CLEAR: rd_data = 8'(clr_ff);
			ADDR_SCROLL: rd_data = busy_ff ? REG_RESET : 8'(scroll_ff);
			ADDR_SPERIOD: rd_data = 8'(sper_ff);
			ADDR_COLOUR: rd_data = 8'(colour_ff);
			ADDR_CSOURCE: rd_data = 8'(src_ff);
			ADDR_STATUS: rd_data = 8'(flag_ff);
			default: rd_data = REG_RESET;
		endcase
	end

	logic            rep_run, scl_run, rep_tick_end, scl_tick_end;
	logic [RT_W-1:0] rtick_ff, nxt_rtick;
	logic [ST_W-1:0] stick_ff, nxt_stick;
	logic [1:0]      runit_ff, nxt_runit;
	logic [2:0]      sunit_ff, nxt_sunit, col_ff, nxt_col;
	logic [7:0]      frame_ff, nxt_frame;
	logic            buf_ff, nxt_buf;

	assign rep_run      = matrix_ff && repeat_ff;
	assign scl_run      = matrix_ff && scroll_ff;
	assign rep_tick_end = rtick_ff == RT_W'(FRAME_UNIT_CYC - 1);
	assign scl_tick_end = stick_ff == ST_W'(SCROLL_UNIT_CYC - 1);

	always_comb begin
		nxt_rtick = '0;
		nxt_runit = 2'h0;
		nxt_frame = first_ff;
		if (rep_run) begin
			nxt_rtick = rtick_ff + RT_W'(1);
			nxt_runit = runit_ff;
			nxt_frame = frame_ff;
			if (rep_tick_end) begin
				nxt_rtick = '0;
				nxt_runit = runit_ff + 2'h1;
				if (runit_ff == rper_ff) begin
					nxt_runit = 2'h0;
					nxt_frame = (frame_ff == last_ff) ? first_ff : frame_ff + 8'h01;
				end
			end
		end
	end

	always_comb begin
		nxt_stick = '0;
		nxt_sunit = 3'h0;
		nxt_col   = 3'h0;
		nxt_buf   = 1'b0;
		if (scl_run) begin
			nxt_stick = stick_ff + ST_W'(1);
			nxt_sunit = sunit_ff;
			nxt_col   = col_ff;
			nxt_buf   = buf_ff;
			if (scl_tick_end) begin
				nxt_stick = '0;
				nxt_sunit = sunit_ff + 3'h1;
				if (sunit_ff == scroll_last_unit(sper_ff)) begin
					nxt_sunit = 3'h0;
					nxt_col   = (col_ff == COLUMN_LAST) ? 3'h0 : col_ff + 3'h1;
					if (col_ff == COLUMN_LAST) nxt_buf = ~buf_ff;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rtick_ff <= '0;
			runit_ff <= 2'h0;
			frame_ff <= REG_RESET;
			stick_ff <= '0;
			sunit_ff <= 3'h0;
			col_ff   <= 3'h0;
			buf_ff   <= 1'b0;
		end else begin
			rtick_ff <= nxt_rtick;
			runit_ff <= nxt_runit;
			frame_ff <= nxt_frame;
			stick_ff <= nxt_stick;
			sunit_ff <= nxt_sunit;
			col_ff   <= nxt_col;
			buf_ff   <= nxt_buf;
		end
	end

	// Pattern writes pass through; in scroll they go to the buffer not shown
	logic       pstb_ff, nxt_pstb, pbuf_ff, nxt_pbuf;
	logic [6:0] paddr_ff, nxt_paddr;
	logic [7:0] pdata_ff, nxt_pdata;

	always_comb begin
		nxt_pstb  = wr_stb && wa >= ADDR_PAT_LO && wa <= ADDR_PAT_HI;
		nxt_paddr = nxt_pstb ? wa : paddr_ff;
		nxt_pdata = nxt_pstb ? wr_data : pdata_ff;
		nxt_pbuf  = nxt_pstb ? (scl_run & ~buf_ff) : pbuf_ff;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pstb_ff  <= 1'b0;
			paddr_ff <= 7'h00;
			pdata_ff <= 8'h00;
			pbuf_ff  <= 1'b0;
		end else begin
			pstb_ff  <= nxt_pstb;
			paddr_ff <= nxt_paddr;
			pdata_ff <= nxt_pdata;
			pbuf_ff  <= nxt_pbuf;
		end
	end

	assign matrix_on            = matrix_ff;
	assign repeat_active        = rep_run;
	assign display_frame        = frame_ff;
	assign scroll_active        = scl_run;
	assign scroll_buffer        = buf_ff;
	assign scroll_column        = col_ff;
	assign pattern_wr_stb       = pstb_ff;
	assign pattern_wr_addr      = paddr_ff;
	assign pattern_wr_data      = pdata_ff;
	assign pattern_wr_buffer    = pbuf_ff;
	assign clear_buffer_one     = clr_ff[BIT_CLR_ONE];
	assign clear_buffer_two     = clr_ff[BIT_CLR_TWO];
	assign rom_copy_busy        = busy_ff;
	assign colour_unit_on       = colour_ff;
	assign colour_source_select = src_ff;
	assign copy_active_flag     = flag_ff;

	clear_pulse_len_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(clear_buffer_one) |-> clear_buffer_one ##1 clear_buffer_one ##1 !clear_buffer_one)
		else $error("buffer one clear not two cycles");
	copy_busy_len_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(rom_copy_busy) |-> ##50 rom_copy_busy ##1 !rom_copy_busy)
		else $error("copy busy not 51 cycles");
	repeat_refused_a: assert property (@(posedge clk) disable iff (!reset_n)
		busy_ff && wr_stb && wa == ADDR_REPEAT |=> $stable(repeat_ff) && copy_active_flag)
		else $error("repeat write taken during copy");
	scroll_refused_a: assert property (@(posedge clk) disable iff (!reset_n)
		busy_ff && wr_stb && wa == ADDR_SCROLL |=> $stable(scroll_ff) && copy_active_flag)
		else $error("scroll write taken during copy");
	scroll_takes_over_a: assert property (@(posedge clk) disable iff (!reset_n)
		!busy_ff && wr_stb && wa == ADDR_SCROLL && wr_data[0] && !scroll_ff && repeat_ff
		|=> !repeat_ff && scroll_ff)
		else $error("scroll start did not clear repeat");
	repeat_takes_over_a: assert property (@(posedge clk) disable iff (!reset_n)
		!busy_ff && wr_stb && wa == ADDR_REPEAT && wr_data[0] && !repeat_ff && scroll_ff
		|=> repeat_ff && !scroll_ff)
		else $error("repeat start did not clear scroll");
	frame_start_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(repeat_active) |-> display_frame == first_ff)
		else $error("repeat did not start at first frame");
	column_order_a: assert property (@(posedge clk) disable iff (!reset_n)
		scroll_active && $past(scroll_active) && $changed(scroll_column)
		|-> scroll_column == (($past(scroll_column) == COLUMN_LAST) ? 3'h0 : $past(scroll_column) + 3'h1))
		else $error("scroll column out of order");
	upper_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
		rd_load && rd_addr[ADDR_W-1:0] != ADDR_FIRST && rd_addr[ADDR_W-1:0] != ADDR_LAST |-> rd_data[7:6] == 2'h0)
		else $error("unused upper bits read nonzero");
endmodule // lmsc_sequencer

//--- sim/lmsc_host_model.sv
// Purpose: host side of the serial register port
// Assumes: link clock of 125 ns, standing low between frames
// Notes: callers never clear during scroll or copy, never touch 0x2E
module lmsc_host_model (
	output logic      ser_clk,
	output logic      ser_ce,
	output logic      ser_di,
	input  wire logic ser_do
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		ser_clk = 1'b0;
		ser_ce  = 1'b0;
		ser_di  = 1'b0;
	end

	// Address byte then data byte, MSB first; read data taken on the data rises
	task automatic frame(input logic [7:0] addr, input logic [7:0] data, output logic [7:0] rdata);
		logic [15:0] sh;
		sh     = {addr, data};
		rdata  = 8'h00;
		ser_ce = 1'b1;
		for (int i = 15; i >= 0; i--) begin
			ser_di = sh[i];
			#62.5;
			ser_clk = 1'b1;
			if (i < 8)
				rdata[i] = ser_do;
			#62.5;
			ser_clk = 1'b0;
		end
		ser_ce = 1'b0;
		// Released line shows the inverse of its last bit
		ser_di = ~ser_di;
		#125;
	endtask
endmodule // lmsc_host_model

//--- sim/lmsc_sequencer_bench.sv
// Purpose: self-checking bench for the sequence control block
// Assumes: shortened frame and scroll units, 125 ns link clock
// Notes: read bytes and pattern writes are compared against queued notes
module lmsc_sequencer_bench import lmsc_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned FU = 20;
	localparam int unsigned SU = 10;
	localparam logic [6:0] REGS [6] = '{ADDR_FIRST, ADDR_LAST, ADDR_RPERIOD, ADDR_SPERIOD, ADDR_COLOUR, ADDR_CSOURCE};
	localparam logic [7:0] MASKS [6] = '{8'hFF, 8'hFF, MASK_PERIOD, MASK_PERIOD, MASK_BIT0, MASK_SOURCE};

	logic        clk, reset_n, ser_clk, ser_ce, ser_di, ser_do, ser_do_oe;
	logic        matrix_on, repeat_active, scroll_active, scroll_buffer, pattern_wr_stb, pattern_wr_buffer;
	logic        clear_buffer_one, clear_buffer_two, rom_copy_busy, colour_unit_on, copy_active_flag;
	logic [7:0]  display_frame, pattern_wr_data, rd_byte, prev_frame;
	logic [6:0]  pattern_wr_addr;
	logic [5:0]  colour_source_select;
	logic [2:0]  scroll_column, prev_col;
	logic        prev_buf;
	logic        prev_act = 1'b0;
	logic [7:0]  rd_q [$];
	logic [15:0] pat_q [$];
	int          fails = 0;
	int          compares = 0;
	int          seed = 37;
	int          clr1, clr2, busy_cnt, frame_gap, frame_cnt, col_gap, col_cnt, oe_cnt;
	event        rd_done;

	lmsc_sequencer #(.FRAME_UNIT_CYC(FU), .SCROLL_UNIT_CYC(SU)) i_lmsc_sequencer (
		.clk(clk), .reset_n(reset_n), .ser_clk(ser_clk), .ser_ce(ser_ce), .ser_di(ser_di),
		.ser_do(ser_do), .ser_do_oe(ser_do_oe), .matrix_on(matrix_on), .repeat_active(repeat_active),
		.display_frame(display_frame), .scroll_active(scroll_active), .scroll_buffer(scroll_buffer),
		.scroll_column(scroll_column), .pattern_wr_stb(pattern_wr_stb), .pattern_wr_addr(pattern_wr_addr),
		.pattern_wr_data(pattern_wr_data), .pattern_wr_buffer(pattern_wr_buffer),
		.clear_buffer_one(clear_buffer_one), .clear_buffer_two(clear_buffer_two),
		.rom_copy_busy(rom_copy_busy), .colour_unit_on(colour_unit_on),
		.colour_source_select(colour_source_select), .copy_active_flag(copy_active_flag)
	);
	lmsc_host_model i_lmsc_host_model (.ser_clk(ser_clk), .ser_ce(ser_ce), .ser_di(ser_di), .ser_do(ser_do));

	initial clk = 1'b0;
	always #5 clk = ~clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		compares++;
		if (seen !== want) begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic report_and_stop();
		if (fails == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		oe_cnt = 0;
		i_lmsc_host_model.frame({1'b0, a}, d, q);
		check(16'(oe_cnt), 16'h0000);
		repeat (6) @(posedge clk);
		#1;
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] want);
		logic [7:0] q;
		rd_q.push_back(want);
		oe_cnt = 0;
		i_lmsc_host_model.frame({1'b1, a}, 8'h00, q);
		check(16'(oe_cnt > 0), 16'h0001);
		rd_byte = q;
		-> rd_done;
		@(posedge clk);
		#1;
	endtask

	always @(rd_done) check(16'(rd_byte), 16'(rd_q.pop_front()));

	always @(posedge clk) begin
		if (pattern_wr_stb === 1'b1) begin
			check(16'({pattern_wr_addr, pattern_wr_data}), pat_q.pop_front());
			check(16'(pattern_wr_buffer), 16'(!prev_buf));
		end
		if (clear_buffer_one === 1'b1)
			clr1++;
		if (clear_buffer_two === 1'b1)
			clr2++;
		if (rom_copy_busy === 1'b1)
			busy_cnt++;
		if (ser_do_oe === 1'b1)
			oe_cnt++;
		if (repeat_active === 1'b1 && display_frame !== prev_frame) begin
			frame_gap = frame_cnt + 1;
			frame_cnt = 0;
		end else
			frame_cnt++;
		if (scroll_active === 1'b1 && prev_act && scroll_column !== prev_col) begin
			check(16'({scroll_column, scroll_buffer}), 16'({(prev_col == COLUMN_LAST) ? 3'h0 : prev_col + 3'h1,
				(prev_col == COLUMN_LAST) ^ prev_buf}));
			col_gap = col_cnt + 1;
			col_cnt = 0;
		end else
			col_cnt++;
		prev_frame = display_frame;
		prev_col   = scroll_column;
		prev_buf   = scroll_buffer;
		prev_act   = (scroll_active === 1'b1);
	end

	initial begin
		#400us;
		fails++;
		report_and_stop();
	end

	initial begin
		logic [7:0] v [6];
		logic [7:0] d;
		reset_n = 1'b0;
		repeat (5) @(posedge clk);
		#1 reset_n = 1'b1;
		rd(ADDR_MATRIX, 8'h00);
		for (int a = 'h25; a <= 'h2D; a++)
			rd(7'(a), 8'h00);
		wr(7'h70, 8'(($random(seed))));
		rd(7'h70, 8'h00);
		// Oscillator taken as settled long before colour writes
		foreach (REGS[i]) begin
			v[i] = 8'($random(seed));
			wr(REGS[i], v[i]);
			rd(REGS[i], v[i] & MASKS[i]);
		end
		check(16'(colour_source_select), 16'(v[5] & MASK_SOURCE));
		check(16'(colour_unit_on), 16'(v[4][0]));
		// Clear first, copy afterwards, so no clear ever follows a copy
		clr1 = 0;
		clr2 = 0;
		wr(ADDR_CLEAR, 8'h03);
		check(16'(clr1), 16'h0002);
		check(16'(clr2), 16'h0002);
		rd(ADDR_CLEAR, 8'h00);
		busy_cnt = 0;
		wr(ADDR_COPY, 8'h01);
		repeat (60) @(posedge clk);
		check(16'(busy_cnt), 16'd51);
		wr(ADDR_FIRST, 8'h95);
		wr(ADDR_LAST, 8'h96);
		wr(ADDR_MATRIX, 8'h01);
		check(16'(repeat_active), 16'h0000);
		wr(ADDR_REPEAT, 8'h01);
		check(16'(repeat_active), 16'h0001);
		for (int p = 0; p < 4; p++) begin
			wr(ADDR_RPERIOD, 8'(p));
			repeat ((p + 2) * FU * 3) @(posedge clk);
			#1;
			check(16'(frame_gap), 16'((p + 1) * FU));
			check(16'(display_frame === 8'h95 || display_frame === 8'h96), 16'h0001);
		end
		wr(ADDR_SCROLL, 8'h01);
		rd(ADDR_REPEAT, 8'h00);
		check(16'({scroll_active, repeat_active}), 16'h0002);
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_SPERIOD, 8'(s));
			d = 8'($random(seed));
			pat_q.push_back({1'b0, (s[0] ? ADDR_PAT_HI : ADDR_PAT_LO), d});
			wr(s[0] ? ADDR_PAT_HI : ADDR_PAT_LO, d);
			repeat ((SU << s) * 3) @(posedge clk);
			#1;
			check(16'(col_gap), 16'(SU << s));
		end
		wr(ADDR_REPEAT, 8'h01);
		rd(ADDR_SCROLL, 8'h00);
		check(16'({scroll_active, repeat_active}), 16'h0001);
		wr(ADDR_MATRIX, 8'h00);
		check(16'({matrix_on, repeat_active}), 16'h0000);
		check(16'(copy_active_flag), 16'h0000);
		// Scroll was stopped, so reset before any later scroll use
		@(posedge clk);
		#1 reset_n = 1'b0;
		@(posedge clk);
		#1 reset_n = 1'b1;
		rd(ADDR_FIRST, 8'h00);
		rd(ADDR_REPEAT, 8'h00);
		report_and_stop();
	end
endmodule // lmsc_sequencer_bench
